// ==== common/asc_pkg.sv ====
package asc_pkg;

   // ==========================================
   // Bus geometry
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int REG_W = 8;

   // ==========================================
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_DIV_SW_CTRL = 8'h71;
   localparam logic [7:0] IDX_DIV_RESULT = 8'h72;
   localparam logic [7:0] IDX_ANT0_ENERGY = 8'h73;
   localparam logic [7:0] IDX_ANT1_ENERGY = 8'h74;
   localparam logic [7:0] IDX_SW_FORCE = 8'h75;
   localparam logic [7:0] IDX_SW_OPTION = 8'h7E;
   localparam logic [7:0] IDX_SW_STATUS = 8'h7F;

   // ==========================================
   // Field positions
   localparam int DIV_EN_BIT = 0;
   localparam int DUAL_PORT_BIT = 1;
   localparam int PATH_INV_BIT = 2;
   localparam int ANT_INV_BIT = 3;
   localparam int ANT_CTRL_SEL_BIT = 5;
   localparam int RES_DONE_BIT = 0;
   localparam int RES_SEL_ANT_BIT = 1;
   localparam int PATH_FORCE_EN_BIT = 0;
   localparam int ANT_FORCE_EN_BIT = 1;
   localparam int PATH_FORCE_LVL_BIT = 4;
   localparam int ANT_FORCE_LVL_BIT = 5;
   localparam int OPT_FIX_EN_BIT = 0;
   localparam int ST_ANT_PIN_BIT = 0;
   localparam int ST_PATH_PIN_BIT = 1;
   localparam int ST_SEARCH_BIT = 2;
   localparam int ST_RADIO_LSB = 4;

   // ==========================================
   // Reset values
   localparam logic [REG_W-1:0] RST_REG = 8'h00;
   localparam logic [APB_DW-1:0] RST_WORD = 32'h00000000;

   // ==========================================
   // Types
   typedef enum logic [1:0] {
      RADIO_IDLE = 2'b00,
      RADIO_TX = 2'b01,
      RADIO_RX = 2'b10
   } asc_radio_e;

   typedef enum logic [1:0] {
      SRCH_IDLE = 2'b00,
      SRCH_ANT0 = 2'b01,
      SRCH_ANT1 = 2'b10,
      SRCH_DONE = 2'b11
   } asc_srch_e;

   typedef struct packed {
      logic antCtrlSel;
      logic antInv;
      logic pathInv;
      logic dualPort;
      logic divEn;
   } asc_ctrl_s;

   typedef struct packed {
      logic antLevel;
      logic pathLevel;
      logic antEnable;
      logic pathEnable;
   } asc_force_s;

   typedef struct packed {
      logic searching;
      logic done;
      logic curAnt;
      logic selAnt;
   } asc_div_s;

endpackage

// ==== hdl/asc_div_search.sv ====
`timescale 1ns/1ps
module asc_div_search
   import asc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic start,
   input wire logic edValid,
   input wire logic [REG_W-1:0] edValue,
   input wire logic clearDone,
   output asc_div_s div,
   output logic [REG_W-1:0] ant0Energy,
   output logic [REG_W-1:0] ant1Energy
);

   asc_srch_e state_q;
   logic curAnt_q;
   logic selAnt_q;
   logic done_q;
   logic [REG_W-1:0] ed0_q;
   logic [REG_W-1:0] ed1_q;

   // ==========================================
   // Search sequence
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= SRCH_IDLE;
      end else if (ce) begin
         unique case (state_q)
            SRCH_IDLE: begin
               if (start && !done_q) begin
                  state_q <= SRCH_ANT0;
               end
            end
            SRCH_ANT0: begin
               if (!start) begin
                  state_q <= SRCH_IDLE;
               end else if (edValid) begin
                  state_q <= SRCH_ANT1;
               end
            end
            SRCH_ANT1: begin
               if (!start) begin
                  state_q <= SRCH_IDLE;
               end else if (edValid) begin
                  state_q <= SRCH_DONE;
               end
            end
            SRCH_DONE: begin
               if (!start) begin
                  state_q <= SRCH_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Energy capture and antenna choice
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ed0_q <= RST_REG;
         ed1_q <= RST_REG;
         curAnt_q <= 1'b0;
         selAnt_q <= 1'b0;
      end else if (ce) begin
         if (state_q == SRCH_IDLE && start && !done_q) begin
            curAnt_q <= 1'b0;
         end else if (state_q == SRCH_ANT0 && start && edValid) begin
            ed0_q <= edValue;
            curAnt_q <= 1'b1;
         end else if (state_q == SRCH_ANT1 && start && edValid) begin
            ed1_q <= edValue;
            selAnt_q <= edValue > ed0_q;
            curAnt_q <= edValue > ed0_q;
         end
      end
   end

   // Done flag: a completion in the clearing cycle wins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         done_q <= 1'b0;
      end else if (ce) begin
         if (state_q == SRCH_ANT1 && start && edValid) begin
            done_q <= 1'b1;
         end else if (clearDone) begin
            done_q <= 1'b0;
         end
      end
   end

   assign div = '{searching: (state_q == SRCH_ANT0) || (state_q == SRCH_ANT1),
                  done: done_q, curAnt: curAnt_q, selAnt: selAnt_q};
   assign ant0Energy = ed0_q;
   assign ant1Energy = ed1_q;

endmodule // asc_div_search

// ==== hdl/asc_switch_ctrl.sv ====
`timescale 1ns/1ps
module asc_switch_ctrl
   import asc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] radioState,
   input wire logic edValid,
   input wire logic [REG_W-1:0] edValue,
   output logic antennaSelectPin,
   output logic pathSelectPin
);

   // ==========================================
   // Registers and bus state
   asc_ctrl_s ctrl_q;
   asc_force_s force_q;
   logic fixEn_q;
   logic selAntSw_q;
   logic pready_q;
   logic pslverr_q;
   logic [APB_DW-1:0] prdata_q;
   logic antPin_q;
   logic antPin_d;
   logic pathPin_q;
   logic pathPin_d;
   asc_div_s div;
   logic [REG_W-1:0] ant0Energy;
   logic [REG_W-1:0] ant1Energy;
   logic [7:0] regIdx;
   logic addrAligned;
   logic mapped;
   logic access;
   logic wrEn;
   logic wrLane0;
   logic clearDone;
   logic searchStart;
   logic divHold;
   logic antLevel;
   logic [REG_W-1:0] rdByte;
   logic [REG_W-1:0] ctrlByte;
   logic [REG_W-1:0] resultByte;
   logic [REG_W-1:0] forceByte;
   logic [REG_W-1:0] statusByte;
   asc_radio_e radio;

   assign radio = asc_radio_e'(radioState);

   // ==========================================
   // APB decode
   assign regIdx = paddr[9:2];
   assign addrAligned = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == 2'b00);
   always_comb begin
      mapped = 1'b0;
      if (addrAligned) begin
         unique case (regIdx)
            IDX_DIV_SW_CTRL, IDX_DIV_RESULT, IDX_ANT0_ENERGY, IDX_ANT1_ENERGY,
            IDX_SW_FORCE, IDX_SW_OPTION, IDX_SW_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Access completes on the second access-phase edge
   assign access = psel && penable && pready_q;
   assign wrEn = access && pwrite && mapped;
   assign wrLane0 = wrEn && pstrb[0];

   // ==========================================
   // APB handshake
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pready_q <= 1'b0;
      end else if (ce) begin
         pready_q <= psel && penable && !pready_q;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pslverr_q <= psel && penable && !pready_q && !mapped;
      end
   end

   // ==========================================
   // Read data
   assign ctrlByte = {2'b00, ctrl_q.antCtrlSel, 1'b0, ctrl_q.antInv, ctrl_q.pathInv,
                      ctrl_q.dualPort, ctrl_q.divEn};
   always_comb begin
      resultByte = RST_REG;
      resultByte[RES_DONE_BIT] = div.done;
      resultByte[RES_SEL_ANT_BIT] = ctrl_q.divEn ? div.selAnt : selAntSw_q;
   end
   always_comb begin
      forceByte = RST_REG;
      forceByte[PATH_FORCE_EN_BIT] = force_q.pathEnable;
      forceByte[ANT_FORCE_EN_BIT] = force_q.antEnable;
      forceByte[PATH_FORCE_LVL_BIT] = force_q.pathLevel;
      forceByte[ANT_FORCE_LVL_BIT] = force_q.antLevel;
   end
   always_comb begin
      statusByte = RST_REG;
      statusByte[ST_ANT_PIN_BIT] = antPin_q;
      statusByte[ST_PATH_PIN_BIT] = pathPin_q;
      statusByte[ST_SEARCH_BIT] = div.searching;
      statusByte[ST_RADIO_LSB +: 2] = radioState;
   end
   always_comb begin
      unique case (regIdx)
         IDX_DIV_SW_CTRL: rdByte = ctrlByte;
         IDX_DIV_RESULT: rdByte = resultByte;
         IDX_ANT0_ENERGY: rdByte = ant0Energy;
         IDX_ANT1_ENERGY: rdByte = ant1Energy;
         IDX_SW_FORCE: rdByte = forceByte;
         IDX_SW_OPTION: rdByte = {7'h00, fixEn_q};
         IDX_SW_STATUS: rdByte = statusByte;
         default: rdByte = RST_REG;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata_q <= RST_WORD;
      end else if (ce) begin
         if (psel && penable && !pready_q && !pwrite && mapped) begin
            prdata_q <= {{(APB_DW-REG_W){1'b0}}, rdByte};
         end else if (psel && penable && !pready_q) begin
            prdata_q <= RST_WORD;
         end
      end
   end

   // ==========================================
   // Writable registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= '0;
      end else if (ce) begin
         if (wrLane0 && regIdx == IDX_DIV_SW_CTRL) begin
            ctrl_q.divEn <= pwdata[DIV_EN_BIT];
            ctrl_q.dualPort <= pwdata[DUAL_PORT_BIT];
            ctrl_q.pathInv <= pwdata[PATH_INV_BIT];
            ctrl_q.antInv <= pwdata[ANT_INV_BIT];
            ctrl_q.antCtrlSel <= pwdata[ANT_CTRL_SEL_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         force_q <= '0;
      end else if (ce) begin
         if (wrLane0 && regIdx == IDX_SW_FORCE) begin
            force_q.pathEnable <= pwdata[PATH_FORCE_EN_BIT];
            force_q.antEnable <= pwdata[ANT_FORCE_EN_BIT];
            force_q.pathLevel <= pwdata[PATH_FORCE_LVL_BIT];
            force_q.antLevel <= pwdata[ANT_FORCE_LVL_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fixEn_q <= 1'b0;
      end else if (ce) begin
         if (wrLane0 && regIdx == IDX_SW_OPTION) begin
            fixEn_q <= pwdata[OPT_FIX_EN_BIT];
         end
      end
   end

   // Software antenna choice, only taken while diversity is off
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         selAntSw_q <= 1'b0;
      end else if (ce) begin
         if (wrLane0 && regIdx == IDX_DIV_RESULT && !ctrl_q.divEn) begin
            selAntSw_q <= pwdata[RES_SEL_ANT_BIT];
         end
      end
   end

   assign clearDone = wrLane0 && (regIdx == IDX_DIV_RESULT) && pwdata[RES_DONE_BIT];

   // ==========================================
   // Diversity search engine
   assign searchStart = ctrl_q.divEn && (radio == RADIO_RX);

   asc_div_search u_search (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .start(searchStart),
      .edValid(edValid),
      .edValue(edValue),
      .clearDone(clearDone),
      .div(div),
      .ant0Energy(ant0Energy),
      .ant1Energy(ant1Energy)
   );

   // Searching toggles, completion holds the chosen antenna
   assign divHold = searchStart && (div.searching || div.done);
   assign antLevel = div.searching ? div.curAnt : div.selAnt;

   // ==========================================
   // Pin level selection
   always_comb begin
      antPin_d = 1'b0;
      pathPin_d = 1'b0;
      if (ctrl_q.dualPort) begin
         if (divHold) begin
            antPin_d = !antLevel;
            pathPin_d = antLevel;
         end else if (radio == RADIO_TX) begin
            antPin_d = 1'b0;
            pathPin_d = 1'b1;
         end else begin
            antPin_d = 1'b1;
            pathPin_d = 1'b0;
         end
         if (ctrl_q.pathInv) begin
            antPin_d = !antPin_d;
            pathPin_d = !pathPin_d;
         end
      end else begin
         antPin_d = divHold ? antLevel : 1'b0;
         pathPin_d = (radio == RADIO_TX);
         if (ctrl_q.antInv && ctrl_q.antCtrlSel) begin
            antPin_d = !antPin_d;
         end else if (ctrl_q.pathInv) begin
            pathPin_d = !pathPin_d;
         end
      end
      // Fixed levels apply only with diversity off
      if (fixEn_q && !ctrl_q.divEn) begin
         antPin_d = selAntSw_q;
         pathPin_d = ctrl_q.pathInv;
      end
      if (force_q.antEnable) begin
         antPin_d = force_q.antLevel;
      end
      if (force_q.pathEnable) begin
         pathPin_d = force_q.pathLevel;
      end
   end

   // ==========================================
   // Registered pins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         antPin_q <= 1'b0;
         pathPin_q <= 1'b0;
      end else if (ce) begin
         antPin_q <= antPin_d;
         pathPin_q <= pathPin_d;
      end
   end

   assign antennaSelectPin = antPin_q;
   assign pathSelectPin = pathPin_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

endmodule // asc_switch_ctrl

// ==== tb/asc_rf_switch_model.sv ====
`timescale 1ns/1ps
module asc_rf_switch_model (
   input wire logic clk_sys,
   input wire logic dualPort,
   input wire logic antennaSelectPin,
   input wire logic measure,
   input wire logic [7:0] energy0,
   input wire logic [7:0] energy1,
   output logic edValid,
   output logic [7:0] edValue
);
   logic antIdx;
   logic vld = 1'h0;
   logic [7:0] val = 8'hA5;
   // Dual switch: high pin connects antenna 0
   assign antIdx = dualPort ? !antennaSelectPin : antennaSelectPin;
   assign edValid = vld;
   assign edValue = val;
   // Energy of the connected antenna, noise pattern otherwise
   always @(posedge clk_sys) begin
      vld <= measure;
      val <= measure ? (antIdx ? energy1 : energy0) : ~val;
   end
endmodule // asc_rf_switch_model

// ==== tb/asc_switch_ctrl_sva.sv ====
`timescale 1ns/1ps
module asc_switch_ctrl_sva
   import asc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] radioState,
   input wire logic edValid,
   input wire logic antennaSelectPin,
   input wire logic pathSelectPin
);
   // ==========================================
   // Address decode
   logic okAddr;
   assign okAddr = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 &&
      (paddr[9:2] inside {[8'h71:8'h75], 8'h7E, 8'h7F});

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // ==========================================
   // Bus handshake
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access phase");
   ready_bound_a: assert property ((psel && penable && !pready) |-> ##[1:2] pready)
      else $error("pready late");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   bad_addr_err_a: assert property ((pready && !okAddr) |-> pslverr)
      else $error("unmapped address accepted");
   good_addr_ok_a: assert property ((pready && okAddr) |-> !pslverr)
      else $error("mapped address refused");
   rdata_upper_a: assert property ((pready && !pwrite) |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   rdata_hold_a: assert property (!psel |=> $stable(prdata))
      else $error("read data changed while idle");

   // ==========================================
   // Pins
   reset_pins_a: assert property ($rose(resetn) |-> !antennaSelectPin && !pathSelectPin)
      else $error("pins not low after reset");
   pins_steady_a: assert property (($stable(radioState) && !edValid && !psel) [*4]
      |=> $stable({antennaSelectPin, pathSelectPin}))
      else $error("pins moved without cause");
endmodule // asc_switch_ctrl_sva

bind asc_switch_ctrl asc_switch_ctrl_sva asc_switch_ctrl_sva_i (.clk_sys(clk_sys),
   .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .radioState(radioState),
   .edValid(edValid), .antennaSelectPin(antennaSelectPin), .pathSelectPin(pathSelectPin));

// ==== tb/asc_switch_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module asc_switch_ctrl_tb_top
   import asc_pkg::*;
;
   localparam logic [11:0] A_CTRL = {2'h0, IDX_DIV_SW_CTRL, 2'h0};
   localparam logic [11:0] A_RES = {2'h0, IDX_DIV_RESULT, 2'h0};
   localparam logic [11:0] A_E0 = {2'h0, IDX_ANT0_ENERGY, 2'h0};
   localparam logic [11:0] A_E1 = {2'h0, IDX_ANT1_ENERGY, 2'h0};
   localparam logic [11:0] A_FORCE = {2'h0, IDX_SW_FORCE, 2'h0};
   localparam logic [11:0] A_OPT = {2'h0, IDX_SW_OPTION, 2'h0};
   localparam logic [11:0] A_ST = {2'h0, IDX_SW_STATUS, 2'h0};
   logic clk_sys, resetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [1:0] radioState;
   logic edValid, antennaSelectPin, pathSelectPin, dualPort, measure;
   logic [7:0] edValue, energy0, energy1;
   int errCount = 0;
   int compares = 0;

   asc_switch_ctrl asc_switch_ctrl_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .radioState(radioState), .edValid(edValid), .edValue(edValue),
      .antennaSelectPin(antennaSelectPin), .pathSelectPin(pathSelectPin));
   asc_rf_switch_model asc_rf_switch_model_i (.clk_sys(clk_sys), .dualPort(dualPort),
      .antennaSelectPin(antennaSelectPin), .measure(measure), .energy0(energy0),
      .energy1(energy1), .edValid(edValid), .edValue(edValue));

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // Error flag folded into bit 31 of the result
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      int n = 0;
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 20) begin
            errCount++;
            summarize();
         end
      end while (pready !== 1'h1);
      rd = prdata | {pslverr, 31'h0};
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'h1, a, d, x);
      chk({31'h0, x[31]}, 32'h0, "write refused");
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      logic [31:0] x;
      apb(1'h0, a, 32'h0, x);
      chk(x, e, m);
   endtask

   task automatic pc(input logic [1:0] e, input string m);
      repeat (3) @(posedge clk_sys);
      chk({30'h0, antennaSelectPin, pathSelectPin}, {30'h0, e}, m);
   endtask

   task automatic st(input logic [1:0] s, input logic [1:0] e, input string m);
      @(posedge clk_sys);
      radioState <= s;
      pc(e, m);
   endtask

   task automatic meas;
      @(posedge clk_sys);
      measure <= 1'h1;
      @(posedge clk_sys);
      measure <= 1'h0;
      repeat (3) @(posedge clk_sys);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      rdchk(A_CTRL, 32'h0, "ctrl reset");
      rdchk(A_FORCE, 32'h0, "force reset");
      wr(A_CTRL, 32'h2F);
      rdchk(A_CTRL, 32'h2F, "ctrl readback");
      @(posedge clk_sys);
      resetn <= 1'h0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'h1;
      rdchk(A_CTRL, 32'h0, "ctrl after reset");
      st(RADIO_IDLE, 2'h0, "default pins");
      rdchk(12'h100, 32'h80000000, "unmapped read");
      rdchk(A_CTRL + 12'h1, 32'h80000000, "misaligned read");
   endtask

   task automatic t_dual;
      logic [1:0] iv;
      for (int i = 0; i < 2; i++) begin
         iv = {i[0], i[0]};
         wr(A_CTRL, {29'h0, i[0], 2'h2});
         st(RADIO_TX, 2'h1 ^ iv, "dual tx");
         st(RADIO_RX, 2'h2 ^ iv, "dual rx");
         st(RADIO_IDLE, 2'h2 ^ iv, "dual idle");
      end
   endtask

   task automatic t_single;
      logic [7:0] cfg [3] = '{8'h00, 8'h04, 8'h28};
      logic [5:0] ex [3] = '{6'h04, 6'h11, 6'h2E};
      for (int i = 0; i < 3; i++) begin
         wr(A_CTRL, {24'h0, cfg[i]});
         st(RADIO_TX, ex[i][3:2], "single tx");
         st(RADIO_RX, ex[i][1:0], "single rx");
         st(RADIO_IDLE, ex[i][5:4], "single idle");
      end
   endtask

   task automatic t_force;
      wr(A_CTRL, 32'h0);
      for (int v = 0; v < 4; v++) begin
         wr(A_FORCE, {26'h0, v[1], v[0], 4'h3});
         st(RADIO_TX, {v[1], v[0]}, "forced levels");
      end
      wr(A_FORCE, 32'h22);
      st(RADIO_TX, 2'h3, "antenna forced only");
      wr(A_FORCE, 32'h01);
      st(RADIO_TX, 2'h0, "path forced only");
      wr(A_OPT, 32'h1);
      rdchk(A_OPT, 32'h1, "fix option readback");
      wr(A_RES, 32'h2);
      wr(A_FORCE, 32'h03);
      st(RADIO_TX, 2'h0, "force over fix");
      wr(A_FORCE, 32'h0);
      st(RADIO_TX, 2'h2, "fix antenna");
      wr(A_CTRL, 32'h4);
      st(RADIO_TX, 2'h3, "fix path");
      wr(A_CTRL, 32'h5);
      st(RADIO_TX, 2'h0, "fix ignored");
      wr(A_CTRL, 32'h0);
      wr(A_OPT, 32'h0);
      st(RADIO_IDLE, 2'h0, "back to idle");
   endtask

   task automatic t_div;
      energy0 <= 8'h0A;
      energy1 <= 8'h32;
      dualPort <= 1'h1;
      wr(A_CTRL, 32'h3);
      st(RADIO_RX, 2'h2, "dual search first");
      meas();
      pc(2'h1, "dual search second");
      rdchk(A_ST, 32'h26, "status while searching");
      meas();
      pc(2'h1, "dual choice held");
      rdchk(A_RES, 32'h3, "dual result");
      rdchk(A_E0, 32'h0A, "energy first");
      rdchk(A_E1, 32'h32, "energy second");
      st(RADIO_IDLE, 2'h2, "dual idle after");
      wr(A_RES, 32'h1);
      dualPort <= 1'h0;
      energy0 <= 8'h5A;
      energy1 <= 8'h14;
      wr(A_CTRL, 32'h1);
      st(RADIO_RX, 2'h0, "single search first");
      meas();
      pc(2'h2, "single search second");
      meas();
      pc(2'h0, "single choice held");
      rdchk(A_RES, 32'h1, "single result");
      st(RADIO_IDLE, 2'h0, "single idle after");
   endtask

   // Clock enable low for two edges must freeze the pins
   task automatic t_ce;
      @(posedge clk_sys);
      radioState <= RADIO_TX;
      ce <= 1'h0;
      repeat (2) @(posedge clk_sys);
      chk({30'h0, antennaSelectPin, pathSelectPin}, 32'h0, "pins frozen");
      ce <= 1'h1;
      pc(2'h1, "pins after enable");
      st(RADIO_IDLE, 2'h0, "idle after enable");
   endtask

   task automatic summarize;
      if (errCount == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================
   // Clock, watchdog and sequence
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      errCount++;
      summarize();
   end

   initial begin
      resetn = 1'h0;
      ce = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      radioState = RADIO_IDLE;
      dualPort = 1'h0;
      measure = 1'h0;
      energy0 = 8'h00;
      energy1 = 8'h00;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'h1;
      t_reset();
      t_dual();
      t_single();
      t_force();
      t_ce();
      t_div();
      summarize();
   end
endmodule // asc_switch_ctrl_tb_top
